/* File: src/audio_clock_consts.svh */
`ifndef AUDIO_CLOCK_CONSTS_SVH
`define AUDIO_CLOCK_CONSTS_SVH

`define DIV_FIELD_WIDTH 6
`define CHAN_LEN_WIDTH 6
`define SCK_PHASE_WIDTH 2
`define SCK_HALF_LAST 2'h3
`define DIV_FIELD_RESET 6'h00
`define CHAN_LEN_RESET 6'h20
`define COUNT_RESET 6'h00

`endif

/* File: src/audio_clock_gen.sv */
`timescale 1ns/1ps
`include "audio_clock_consts.svh"

// Summary of operation
// RULE_01: Transmit and receive pins face codec's opposite sides.
// RULE_02: Shared lines need exactly one driving party.
// RULE_03: Codec master means both local ports slave.
// RULE_04: System clock runs control and trigger logic.
// RULE_05: Serial timing crosses domains through synchronizers.
// RULE_06: External pin clock may replace internal audio clock.
// RULE_07: Select bit picks divider source clock.
// RULE_08: First divider programmable, one to sixty-four.
// RULE_09: First division equals field value plus one.
// RULE_10: Fixed divide-by-eight makes both bit clocks.
// RULE_11: Word select toggles once per channel period.
// RULE_12: Slave mode needs master clock eight times bit.
// RULE_13: Configuration synchronized before reaching divider or ports.
module audio_clock_gen (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic high_frequency_clock_one,
    input wire logic external_clock_in,
    input wire audio_clock_pkg::clk_src_t clock_select,
    input wire audio_clock_pkg::div_field_t clock_divider,
    input wire audio_clock_pkg::chan_len_t channel_length,
    input wire logic transmit_master,
    input wire logic receive_master,
    output logic transmit_bit_clock_out,
    output logic transmit_bit_clock_oe,
    output logic transmit_word_select_out,
    output logic transmit_word_select_oe,
    output logic receive_bit_clock_out,
    output logic receive_bit_clock_oe,
    output logic receive_word_select_out,
    output logic receive_word_select_oe,
    output logic master_clock_tick,
    output logic bit_clock_fall_tick
);
    import audio_clock_pkg::*;

    // Both source clocks are sampled here, so each must stay below half of sys_clk.
    logic int_meta_q;
    logic int_sync_q;
    logic ext_meta_q;
    logic ext_sync_q;
    logic src_prev_q;
    logic src_level;
    logic src_tick;

    clk_src_t sel_meta_q;
    clk_src_t sel_q;
    div_field_t div_meta_q;
    div_field_t div_q;
    chan_len_t len_meta_q;
    chan_len_t len_q;
    logic txm_meta_q;
    logic txm_q;
    logic rxm_meta_q;
    logic rxm_q;

    logic mclk_tick;
    logic [`SCK_PHASE_WIDTH-1:0] phase_q;
    logic [`SCK_PHASE_WIDTH-1:0] phase_d;
    logic sck_q;
    logic sck_d;
    logic sck_fall;
    logic fall_q;
    chan_len_t bit_q;
    chan_len_t bit_d;
    chan_len_t len_last;
    logic ws_q;
    logic ws_d;
    logic chan_end;

    // Both audio clocks pass two flops before any logic looks at them. [RULE_05] [RULE_06]
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            int_meta_q <= 1'b0;
            int_sync_q <= 1'b0;
            ext_meta_q <= 1'b0;
            ext_sync_q <= 1'b0;
            src_prev_q <= 1'b0;
        end else begin
            int_meta_q <= high_frequency_clock_one;
            int_sync_q <= int_meta_q;
            ext_meta_q <= external_clock_in;
            ext_sync_q <= ext_meta_q;
            src_prev_q <= src_level;
        end
    end

    // Configuration crosses through two stages before it steers anything. [RULE_13]
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            sel_meta_q <= SRC_INTERNAL;
            sel_q <= SRC_INTERNAL;
            div_meta_q <= `DIV_FIELD_RESET;
            div_q <= `DIV_FIELD_RESET;
            len_meta_q <= `CHAN_LEN_RESET;
            len_q <= `CHAN_LEN_RESET;
            txm_meta_q <= 1'b0;
            txm_q <= 1'b0;
            rxm_meta_q <= 1'b0;
            rxm_q <= 1'b0;
        end else begin
            sel_meta_q <= clock_select;
            sel_q <= sel_meta_q;
            div_meta_q <= clock_divider;
            div_q <= div_meta_q;
            len_meta_q <= channel_length;
            len_q <= len_meta_q;
            txm_meta_q <= transmit_master;
            txm_q <= txm_meta_q;
            rxm_meta_q <= receive_master;
            rxm_q <= rxm_meta_q;
        end
    end

    // Switching source can give one short or long master clock period.
    assign src_level = (sel_q == SRC_EXTERNAL) ? ext_sync_q : int_sync_q; // [RULE_07]
    assign src_tick = src_level && !src_prev_q;

    tick_divider first_stage (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .step_en(src_tick),
        .limit(div_q),
        .tick(mclk_tick)
    );

    // Four master clock ticks per half period gives the fixed division by eight. [RULE_10]
    assign phase_d = mclk_tick ? phase_q + 2'h1 : phase_q;
    assign sck_d = (mclk_tick && phase_q == `SCK_HALF_LAST) ? !sck_q : sck_q;
    assign sck_fall = mclk_tick && phase_q == `SCK_HALF_LAST && sck_q;

    // A channel length of zero behaves as one bit per channel.
    assign len_last = (len_q == 6'h00) ? 6'h00 : len_q - 6'h01;
    assign chan_end = sck_fall && at_limit(bit_q, len_last);
    assign bit_d = chan_end ? `COUNT_RESET : (sck_fall ? bit_q + 6'h01 : bit_q);
    assign ws_d = chan_end ? !ws_q : ws_q; // [RULE_11]

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            phase_q <= 2'h0;
            sck_q <= 1'b0;
            bit_q <= `COUNT_RESET;
            ws_q <= 1'b0;
            fall_q <= 1'b0;
        end else begin
            phase_q <= phase_d;
            sck_q <= sck_d;
            bit_q <= bit_d;
            ws_q <= ws_d;
            fall_q <= sck_fall;
        end
    end

    // Each port drives its lines only as master; with shared lines software must
    // keep at most one of them master, and both slave when the codec leads. [RULE_02] [RULE_03]
    assign transmit_bit_clock_out = sck_q; // [RULE_01]
    assign transmit_word_select_out = ws_q;
    assign transmit_bit_clock_oe = txm_q;
    assign transmit_word_select_oe = txm_q;
    assign receive_bit_clock_out = sck_q; // [RULE_01]
    assign receive_word_select_out = ws_q;
    assign receive_bit_clock_oe = rxm_q;
    assign receive_word_select_oe = rxm_q;

    // The master clock keeps running in slave mode, where it must be eight times
    // the incoming bit clock for the serial logic to sample it. [RULE_12]
    assign master_clock_tick = mclk_tick;
    assign bit_clock_fall_tick = fall_q; // [RULE_04]

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    sequence s_half_end;
        mclk_tick && phase_q == 2'h3;
    endsequence

    sequence s_sck_flips;
        ##1 sck_q != $past(sck_q);
    endsequence

    // Settings are only comparable once two edges out of reset have filled both stages.
    sequence s_sync_flushed;
        $past(rst_n, 2) && $past(rst_n);
    endsequence

    property p_div_two_stage;
        s_sync_flushed |-> div_q == $past(clock_divider, 2);
    endproperty

    property p_tx_oe_follows;
        s_sync_flushed |-> transmit_bit_clock_oe == $past(transmit_master, 2)
            && transmit_word_select_oe == $past(transmit_master, 2);
    endproperty

    property p_rx_oe_follows;
        s_sync_flushed |-> receive_bit_clock_oe == $past(receive_master, 2)
            && receive_word_select_oe == $past(receive_master, 2);
    endproperty

    property p_src_from_ext;
        sel_q == SRC_EXTERNAL && src_tick |-> ext_sync_q && !$past(src_level);
    endproperty

    a_sck_half_period: assert property (s_half_end |-> s_sck_flips) // [RULE_10]
        else $error("bit clock did not toggle after four master ticks");
    a_sck_steady: assert property (!(mclk_tick && phase_q == 2'h3) |=> $stable(sck_q)) // [RULE_10]
        else $error("bit clock toggled mid half period");
    a_ws_channel_end: assert property (chan_end |=> ws_q != $past(ws_q)) // [RULE_11]
        else $error("word select did not toggle at channel end");
    a_ws_steady: assert property (!chan_end |=> $stable(ws_q)) // [RULE_11]
        else $error("word select toggled inside a channel");
    a_cfg_two_stage: assert property (p_div_two_stage) // [RULE_13]
        else $error("divider setting not delayed by two stages");
    a_src_external: assert property (p_src_from_ext) // [RULE_07]
        else $error("source edge not taken from external clock");
    a_src_internal: assert property (sel_q == SRC_INTERNAL && src_tick |-> int_sync_q) // [RULE_06]
        else $error("source edge not taken from internal clock");
    a_slave_quiet: assert property (p_tx_oe_follows) // [RULE_01]
        else $error("transmit enables do not follow the master setting");
    a_rx_oe_follow: assert property (p_rx_oe_follows) // [RULE_01]
        else $error("receive enables do not follow the master setting");
    a_fall_tick: assert property (sck_fall |=> bit_clock_fall_tick && !sck_q) // [RULE_04]
        else $error("bit clock fall tick misplaced");
    a_phase_advance: assert property (mclk_tick |=> phase_q == $past(phase_q) + 2'h1) // [RULE_10]
        else $error("half period counter missed a master tick");
    a_phase_holds: assert property (!mclk_tick |=> $stable(phase_q)) // [RULE_10]
        else $error("half period counter moved without a master tick");
    a_bit_restart: assert property (chan_end |=> bit_q == 6'h00) // [RULE_11]
        else $error("bit counter did not restart at channel end");
    // A source edge needs a low level in between, so two master ticks never touch.
    a_mclk_single: assert property (mclk_tick |=> !mclk_tick) // [RULE_08]
        else $error("master tick lasted more than one cycle");

endmodule

/* File: src/audio_clock_pkg.sv */
`include "audio_clock_consts.svh"

package audio_clock_pkg;

    typedef enum logic {
        SRC_INTERNAL,
        SRC_EXTERNAL
    } clk_src_t;

    typedef logic [`DIV_FIELD_WIDTH-1:0] div_field_t;
    typedef logic [`CHAN_LEN_WIDTH-1:0] chan_len_t;

    // A count at or past its limit wraps, so a limit lowered mid-count cannot strand it.
    function automatic logic at_limit(input logic [5:0] count, input logic [5:0] limit);
        at_limit = (count >= limit);
    endfunction

endpackage

/* File: src/tick_divider.sv */
`timescale 1ns/1ps
`include "audio_clock_consts.svh"

module tick_divider (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic step_en,
    input wire audio_clock_pkg::div_field_t limit,
    output logic tick
);
    import audio_clock_pkg::*;

    div_field_t count_q;
    div_field_t count_d;
    logic tick_q;
    logic wrap;

    // Division is limit plus one steps per output tick. [RULE_09]
    assign wrap = step_en && at_limit(count_q, limit);
    assign count_d = wrap ? `COUNT_RESET : (step_en ? count_q + 6'h01 : count_q);
    assign tick = tick_q;

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            count_q <= `COUNT_RESET;
            tick_q <= 1'b0;
        end else begin
            count_q <= count_d;
            tick_q <= wrap; // [RULE_08]
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    a_tick_after_wrap: assert property (step_en && count_q >= limit |=> tick_q) // [RULE_08]
        else $error("divider did not tick after reaching its limit");
    a_tick_has_cause: assert property (tick_q |-> $past(step_en && count_q >= limit)) // [RULE_09]
        else $error("divider ticked without reaching its limit");
    a_count_restarts: assert property (wrap |=> count_q == 6'h00) // [RULE_09]
        else $error("divider count did not restart at its limit");
    a_count_holds: assert property (!step_en |=> count_q == $past(count_q)) // [RULE_09]
        else $error("divider count moved without a step");

endmodule

/* File: tb/codec_model.sv */
`timescale 1ns/1ps
module codec_model (
    input wire logic run,
    input wire logic tx_clk_oe,
    input wire logic rx_clk_oe,
    input wire logic tx_sel_oe,
    input wire logic rx_sel_oe,
    output logic ext_clk,
    output logic clash
);
    // The host clock moves on falling sys_clk edges only and stands still when idle.
    initial begin
        ext_clk = 1'b0;
        forever begin
            #300;
            ext_clk = run ? ~ext_clk : 1'b0;
        end
    end
    assign clash = (tx_clk_oe & rx_clk_oe) | (tx_sel_oe & rx_sel_oe);
endmodule

/* File: tb/test_audio_clock_gen.sv */
`timescale 1ns/1ps
module test_audio_clock_gen;
    import audio_clock_pkg::*;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic hf = 1'b0;
    logic run = 1'b0;
    clk_src_t sel = SRC_INTERNAL;
    div_field_t div = 6'h00;
    chan_len_t len = 6'h20;
    logic txm = 1'b0;
    logic rxm = 1'b0;
    logic ext, clash, tsck, toe, tws, twoe, rsck, roe, rws, rwoe, mt, ft;
    int err_count = 0;
    int checked = 0;
    always #50 sys_clk = ~sys_clk;
    always #200 hf = ~hf;
    audio_clock_gen audio_clock_gen_inst (.sys_clk(sys_clk), .rst_n(rst_n),
        .high_frequency_clock_one(hf), .external_clock_in(ext), .clock_select(sel),
        .clock_divider(div), .channel_length(len), .transmit_master(txm),
        .receive_master(rxm), .transmit_bit_clock_out(tsck), .transmit_bit_clock_oe(toe),
        .transmit_word_select_out(tws), .transmit_word_select_oe(twoe),
        .receive_bit_clock_out(rsck), .receive_bit_clock_oe(roe),
        .receive_word_select_out(rws), .receive_word_select_oe(rwoe),
        .master_clock_tick(mt), .bit_clock_fall_tick(ft));
    codec_model codec_model_inst (.run(run), .tx_clk_oe(toe), .rx_clk_oe(roe),
        .tx_sel_oe(twoe), .rx_sel_oe(rwoe), .ext_clk(ext), .clash(clash));
    task automatic wrap_up;
        $display("compares %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        checked++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value at %0t: %s got %0d want %0d", $time, what, seen, exp);
        end
    endtask
    function automatic logic pick(input int w);
        case (w)
            0: pick = mt;
            1: pick = tsck;
            2: pick = tws;
            3: pick = ft;
            4: pick = rsck;
            default: pick = rws;
        endcase
    endfunction
    // Three gaps are timed and the last kept, since a changed setting may give one odd period.
    task automatic gap(input int w, input int exp, input string what);
        logic prev;
        int n;
        for (int k = 0; k < 3; k++) begin
            n = 0;
            prev = pick(w);
            forever begin
                @(negedge sys_clk);
                n++;
                if (pick(w) === 1'b1 && prev !== 1'b1) break;
                prev = pick(w);
                if (n > 20000) begin
                    check(0, 1, "no edge");
                    wrap_up();
                end
            end
        end
        check(n, exp, what);
    endtask
    task automatic test_roles;
        logic [3:0] old;
        for (int i = 0; i < 3; i++) begin
            old = {toe, twoe, roe, rwoe};
            txm = (i == 0);
            rxm = (i == 1);
            @(negedge sys_clk);
            check({toe, twoe, roe, rwoe}, old, "enable too early");
            repeat (3) @(negedge sys_clk);
            check({toe, twoe, roe, rwoe}, {{2{i == 0}}, {2{i == 1}}}, "enables");
            check(clash, 0, "shared line clash");
        end
        check({toe, twoe, roe, rwoe}, 0, "codec master leaves both slave");
        // With both ports slave the master tick still runs for the serial logic.
        gap(0, 4, "slave master tick period");
        txm = 1'b1;
        $display("roles done");
    endtask
    task automatic test_divider;
        int f[4] = '{0, 1, 3, 63};
        foreach (f[i]) begin
            div = f[i][5:0];
            gap(0, 4 * (f[i] + 1), "master tick period");
        end
        for (int d = 0; d < 2; d++) begin
            div = d[5:0];
            gap(1, 32 * (d + 1), "tx bit clock period");
            gap(4, 32 * (d + 1), "rx bit clock period");
            gap(3, 32 * (d + 1), "fall tick period");
        end
        $display("divider done");
    endtask
    task automatic test_word_select;
        int l[3] = '{2, 5, 0};
        div = 6'h00;
        foreach (l[i]) begin
            len = l[i][5:0];
            gap(2, 64 * (l[i] == 0 ? 1 : l[i]), "word select period");
            gap(5, 64 * (l[i] == 0 ? 1 : l[i]), "rx word select period");
        end
        len = 6'h20;
        $display("word select done");
    endtask
    task automatic test_external;
        run = 1'b1;
        sel = SRC_EXTERNAL;
        div = 6'h01;
        gap(0, 12, "external tick period");
        div = 6'h00;
        gap(0, 6, "external tick period");
        sel = SRC_INTERNAL;
        gap(0, 4, "internal tick period");
        $display("external done");
    endtask
    task automatic test_reset;
        rst_n = 1'b0;
        repeat (3) @(negedge sys_clk);
        check({toe, twoe, tsck, tws, mt}, 0, "reset outputs");
        rst_n = 1'b1;
        gap(0, 4, "tick after reset");
        $display("reset done");
    endtask
    initial begin
        repeat (6) @(negedge sys_clk);
        rst_n = 1'b1;
        test_roles();
        test_divider();
        test_word_select();
        test_external();
        test_reset();
        wrap_up();
    end
endmodule
